//--- common/lad_pkg.sv
// Constants and carrier types for the LED driver slave-address decoder.
// Assumes a two-wire serial bus with 7-bit addresses and an R/W bit.
package lad_pkg;

    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int GROUP_N = 3;
    localparam int CNT_W = 4;

    // Filtered SCL must stay high this long before an SDA edge counts
    localparam int SETTLE_W = 3;
    localparam logic [SETTLE_W-1:0] SCL_SETTLE = 3'h6;

    // Bit counter: bits 0..7 of the address byte, then the ack slot
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;
    localparam logic [CNT_W-1:0] ACK_SLOT = 4'h8;

    // Direction bit values
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    // Fixed reset-call address (byte 0000 0110 with R/W cleared)
    localparam logic [ADDR_W-1:0] RESET_CALL_ADDR = 7'h03;

    // Power-up values of the address registers
    localparam logic [BYTE_W-1:0] BROADCAST_RST = 8'he0;
    localparam logic [BYTE_W-1:0] GROUP1_RST = 8'he2;
    localparam logic [BYTE_W-1:0] GROUP2_RST = 8'he4;
    localparam logic [BYTE_W-1:0] GROUP3_RST = 8'he8;

    // Recognition enables: broadcast on, group calls off after power-up
    localparam logic BCAST_EN_RST = 1'b1;
    localparam logic [GROUP_N-1:0] GROUP_EN_RST = 3'h0;

    // Config write selects
    localparam logic [2:0] SEL_BROADCAST = 3'h0;
    localparam logic [2:0] SEL_GROUP1 = 3'h1;
    localparam logic [2:0] SEL_GROUP2 = 3'h2;
    localparam logic [2:0] SEL_GROUP3 = 3'h3;
    localparam logic [2:0] SEL_ENABLES = 3'h4;

    // Field positions in the enables write byte
    localparam int EN_BCAST_BIT = 0;
    localparam int EN_GROUP_LSB = 1;

    typedef struct packed {
        logic [BYTE_W-1:0] broadcast;
        logic [GROUP_N-1:0][BYTE_W-1:0] group;
        logic bcast_en;
        logic [GROUP_N-1:0] group_en;
    } lad_cfg_t;

    typedef struct packed {
        logic regular;
        logic broadcast;
        logic [GROUP_N-1:0] group;
        logic reset_call;
    } lad_hit_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } lad_bus_t;

endpackage : lad_pkg

//--- hw/lad_sync3.sv
// Three-stage synchroniser with agreement filter for slow pin levels.
// Assumes the inputs are levels from outside the clock domain.
`timescale 1ns/1ps
module lad_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;
    logic [W-1:0] q_q;

    // A bit moves only when stages two and three agree
    always_comb
    begin
        q_d = q_q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                q_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            q_q <= INIT;
        end
        else
        begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end

    assign q_out = q_q;

endmodule : lad_sync3

//--- hw/lad_addr_decoder.sv
// Slave-address recognition for a four-channel LED driver.
// Assumes the serial clock is the link clock and the register engine
// that follows the address phase runs on that same clock.
// What this block does
// - Two pins pick four addresses, else fixed
// - Reserved regular addresses accepted like others
// - Last address bit: 1 read, 0 write
// - Broadcast address resets E0h, writable, enabled
// - Default broadcast acked as E0h write, E1h read
// - Group addresses reset E2h, E4h, E8h, writable
// - Group calls disabled after power-up
// - Reset call acked only with write direction
// - Reset call and broadcast active from start-up
// - Accepted reset call restores power-up defaults
// - Acked write, except reset call: next byte is register pointer
`timescale 1ns/1ps
module lad_addr_decoder
#(
    parameter bit TEN_PIN = 1'b1,
    parameter logic [lad_pkg::ADDR_W-1:0] PIN_BASE_ADDR = 7'h60,
    parameter logic [lad_pkg::ADDR_W-1:0] FIXED_ADDR = 7'h62
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_pin_0_in,
    input wire logic addr_pin_1_in,
    input wire logic cfg_we_in,
    input wire logic [2:0] cfg_sel_in,
    input wire logic [lad_pkg::BYTE_W-1:0] cfg_data_in,
    output lad_pkg::lad_cfg_t cfg_out,
    output lad_pkg::lad_hit_t hit_out,
    output logic addr_ack_out,
    output logic read_out,
    output logic pointer_next_out,
    output logic device_reset_out
);
    import lad_pkg::*;

    function automatic lad_hit_t match_addr(
        input logic [BYTE_W-1:0] b,
        input lad_cfg_t c,
        input logic [ADDR_W-1:0] own
    );
        lad_hit_t h;
        h.regular = (b[BYTE_W-1:1] == own);
        h.broadcast = c.bcast_en
            && (b[BYTE_W-1:1] == c.broadcast[BYTE_W-1:1]);
        for (int i = 0; i < GROUP_N; i++)
        begin
            h.group[i] = c.group_en[i]
                && (b[BYTE_W-1:1] == c.group[i][BYTE_W-1:1]);
        end
        h.reset_call = (b[BYTE_W-1:1] == RESET_CALL_ADDR)
            && (b[0] == RW_WRITE);
        return h;
    endfunction : match_addr

    // System clock side: START/STOP watch on filtered bus levels
    lad_bus_t bus_s;
    lad_bus_t bus_prev_q;
    logic start_q;
    logic start_d;
    logic soft_rst_q;
    logic soft_rst_d;
    logic reset_hit_s;
    logic stop_evt;
    // Fast SCL can hold filtered SCL high briefly; need a long high
    logic [SETTLE_W-1:0] scl_hi_q;
    logic [SETTLE_W-1:0] scl_hi_d;

    // Link side state
    logic [CNT_W-1:0] bit_cnt_q;
    logic [CNT_W-1:0] bit_cnt_d;
    logic [BYTE_W-1:0] shift_q;
    logic [BYTE_W-1:0] shift_d;
    logic done_q;
    logic done_d;
    logic ack_q;
    logic ack_d;
    logic read_q;
    logic read_d;
    lad_hit_t hit_q;
    lad_hit_t hit_d;
    logic sda_oe_q;
    logic sda_oe_d;
    lad_cfg_t cfg_q;
    lad_cfg_t cfg_d;
    logic [1:0] pins_s;
    logic [ADDR_W-1:0] own_addr;
    logic frame_rst;
    logic cfg_rst;
    logic reset_hit;

    lad_sync3 #(
        .W(2),
        .INIT(2'h3)
    ) u_bus_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({scl_in, sda_in}),
        .q_out(bus_s)
    );

    // Reset-call hit is a level held until the next START
    lad_sync3 #(
        .W(1),
        .INIT(1'h0)
    ) u_hit_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(reset_hit),
        .q_out(reset_hit_s)
    );

    assign stop_evt = bus_s.scl && bus_prev_q.scl && bus_s.sda
        && !bus_prev_q.sda && (scl_hi_q == SCL_SETTLE);

    always_comb
    begin
        scl_hi_d = (scl_hi_q == SCL_SETTLE) ? scl_hi_q : scl_hi_q + 3'h1;
        scl_hi_d = bus_s.scl ? scl_hi_d : '0;
        start_d = bus_s.scl && bus_prev_q.scl && !bus_s.sda
            && bus_prev_q.sda && (scl_hi_q == SCL_SETTLE);
        // Reset fires at STOP so the frame closes cleanly first
        soft_rst_d = stop_evt && reset_hit_s;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bus_prev_q <= '1;
            scl_hi_q <= '0;
            start_q <= 1'b1;
            soft_rst_q <= 1'b0;
        end
        else
        begin
            bus_prev_q <= bus_s;
            scl_hi_q <= scl_hi_d;
            start_q <= start_d;
            soft_rst_q <= soft_rst_d;
        end
    end

    assign device_reset_out = soft_rst_q;

    // Both resets come straight from flops or the reset pin, no glitches.
    // START reaches the link side long before the first SCL rise.
    assign frame_rst = rst_in | start_q;
    assign cfg_rst = rst_in | soft_rst_q;

    // Straps are static; four link edges settle them before the match
    lad_sync3 #(
        .W(2),
        .INIT(2'h0)
    ) u_pin_sync (
        .clk_in(scl_in),
        .rst_in(rst_in),
        .d_in({addr_pin_1_in, addr_pin_0_in}),
        .q_out(pins_s)
    );

    assign own_addr = TEN_PIN ? {PIN_BASE_ADDR[ADDR_W-1:2], pins_s}
        : FIXED_ADDR;

    // Address byte capture on rising SCL
    always_comb
    begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        done_d = done_q;
        ack_d = ack_q;
        read_d = read_q;
        hit_d = hit_q;
        if (!done_q)
        begin
            if (bit_cnt_q != ACK_SLOT)
            begin
                shift_d = {shift_q[BYTE_W-2:0], sda_in};
                bit_cnt_d = bit_cnt_q + 4'h1;
                if (bit_cnt_q == LAST_BIT)
                begin
                    hit_d = match_addr(shift_d, cfg_q, own_addr);
                    ack_d = hit_d.regular || hit_d.broadcast
                        || (|hit_d.group) || hit_d.reset_call;
                    read_d = (shift_d[0] == RW_READ);
                end
            end
            else
            begin
                // Ack sampled; rest of frame ignored until START
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge scl_in or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            bit_cnt_q <= '0;
            shift_q <= '0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
            read_q <= 1'b0;
            hit_q <= '0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            done_q <= done_d;
            ack_q <= ack_d;
            read_q <= read_d;
            hit_q <= hit_d;
        end
    end

    // Drive low through the ninth clock only on a match
    always_comb
    begin
        sda_oe_d = !done_q && (bit_cnt_q == ACK_SLOT) && ack_q;
    end

    always_ff @(negedge scl_in or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            sda_oe_q <= 1'b0;
        end
        else
        begin
            sda_oe_q <= sda_oe_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_q;

    // Address registers, volatile, rewritten by the pointer engine
    always_comb
    begin
        cfg_d = cfg_q;
        if (cfg_we_in)
        begin
            unique case (cfg_sel_in)
                SEL_BROADCAST: cfg_d.broadcast = cfg_data_in;
                SEL_GROUP1: cfg_d.group[0] = cfg_data_in;
                SEL_GROUP2: cfg_d.group[1] = cfg_data_in;
                SEL_GROUP3: cfg_d.group[2] = cfg_data_in;
                SEL_ENABLES:
                begin
                    cfg_d.bcast_en = cfg_data_in[EN_BCAST_BIT];
                    cfg_d.group_en =
                        cfg_data_in[EN_GROUP_LSB +: GROUP_N];
                end
                default: cfg_d = cfg_q;
            endcase
        end
    end

    always_ff @(posedge scl_in or posedge cfg_rst)
    begin
        if (cfg_rst)
        begin
            cfg_q.broadcast <= BROADCAST_RST;
            cfg_q.group[0] <= GROUP1_RST;
            cfg_q.group[1] <= GROUP2_RST;
            cfg_q.group[2] <= GROUP3_RST;
            cfg_q.bcast_en <= BCAST_EN_RST;
            cfg_q.group_en <= GROUP_EN_RST;
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    assign reset_hit = ack_q && hit_q.reset_call;

    assign cfg_out = cfg_q;
    assign hit_out = hit_q;
    assign addr_ack_out = ack_q;
    assign read_out = read_q;
    assign pointer_next_out = ack_q && !read_q && !hit_q.reset_call;

endmodule : lad_addr_decoder

//--- test/lad_addr_decoder_props.sv
// Assertions on the address decoder, bound to its top module.
// Assumes only the ports of lad_addr_decoder are visible.
`timescale 1ns/1ps
module lad_addr_decoder_props
    import lad_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic cfg_we_in,
    input wire logic [2:0] cfg_sel_in,
    input wire logic [lad_pkg::BYTE_W-1:0] cfg_data_in,
    input wire lad_pkg::lad_cfg_t cfg_out,
    input wire lad_pkg::lad_hit_t hit_out,
    input wire logic addr_ack_out,
    input wire logic read_out,
    input wire logic pointer_next_out,
    input wire logic device_reset_out
);
    localparam lad_cfg_t CFG_DEF = {BROADCAST_RST, GROUP3_RST, GROUP2_RST,
        GROUP1_RST, BCAST_EN_RST, GROUP_EN_RST};
    logic call_hit;
    assign call_hit = hit_out.regular | hit_out.broadcast | (|hit_out.group);
    sequence s_pulse_end;
        !device_reset_out;
    endsequence
    sequence s_ack_drop;
        !sda_oe_out;
    endsequence
    AST_OE_ACK: assert property (@(posedge clk_in) disable iff (rst_in)
        sda_oe_out |-> addr_ack_out) else $error("sda pulled without ack");
    AST_OE_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
        sda_oe_out |-> !sda_out) else $error("sda driven high");
    AST_READ: assert property (@(posedge clk_in) disable iff (rst_in)
        read_out && addr_ack_out |-> !pointer_next_out)
        else $error("acked read taken as pointer write");
    AST_POINTER: assert property (@(posedge clk_in) disable iff (rst_in)
        pointer_next_out == (addr_ack_out && !read_out && call_hit))
        else $error("pointer flag wrong");
    AST_HIT_ACK: assert property (@(posedge clk_in) disable iff (rst_in)
        call_hit |-> addr_ack_out) else $error("match not acked");
    AST_ACK_HIT: assert property (@(posedge clk_in) disable iff (rst_in)
        addr_ack_out |-> hit_out != '0) else $error("ack with no match");
    AST_GROUP_EN: assert property (@(posedge clk_in) disable iff (rst_in)
        (hit_out.group & ~cfg_out.group_en) == '0)
        else $error("disabled group matched");
    AST_RST_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
        hit_out.reset_call && addr_ack_out |-> !read_out)
        else $error("reset call acked as read");
    AST_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
        device_reset_out |-> (cfg_out == CFG_DEF) ##1 s_pulse_end)
        else $error("reset call pulse wrong");
    AST_OE_PERIOD: assert property (@(negedge scl_in) disable iff (rst_in)
        $rose(sda_oe_out) |=> s_ack_drop) else $error("ack too long");
    AST_CFG_WR: assert property (@(posedge scl_in) disable iff (rst_in)
        cfg_we_in && cfg_sel_in == SEL_BROADCAST
        |=> cfg_out.broadcast == $past(cfg_data_in))
        else $error("broadcast write lost");
endmodule : lad_addr_decoder_props
bind lad_addr_decoder lad_addr_decoder_props u_props (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .cfg_we_in(cfg_we_in),
    .cfg_sel_in(cfg_sel_in),
    .cfg_data_in(cfg_data_in),
    .cfg_out(cfg_out),
    .hit_out(hit_out),
    .addr_ack_out(addr_ack_out),
    .read_out(read_out),
    .pointer_next_out(pointer_next_out),
    .device_reset_out(device_reset_out)
);

//--- test/lad_master_model.sv
// Bus master model: START, bytes with ack clock, STOP.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module lad_master_model (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    localparam int HALF = 24;
    localparam int HOLD = 400;
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Long hold: the decoder wants SCL steady high before START or STOP
    task automatic start();
        sda_low_out = 1'b0;
        #HALF scl_out = 1'b1;
        #HOLD sda_low_out = 1'b1;
        #HOLD scl_out = 1'b0;
    endtask : start
    // Data moves 4 ns after the fall, never with the clock edge
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #4 sda_low_out = !b[i];
            #(HALF-4) scl_out = 1'b1;
            #HALF scl_out = 1'b0;
        end
        #4 sda_low_out = 1'b0;
        #(HALF-4) scl_out = 1'b1;
        ack = !sda_in;
        #HALF scl_out = 1'b0;
    endtask : send
    task automatic stop();
        #4 sda_low_out = 1'b1;
        #HALF scl_out = 1'b1;
        #HOLD sda_low_out = 1'b0;
    endtask : stop
endmodule : lad_master_model

//--- test/testbench.sv
// Self-checking bench for the address decoder with a bus master model.
// Assumes the data wire has a pull-up and the model owns the bus clock.
`timescale 1ns/1ps
module testbench;
    import lad_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic scl, sda_low, sda_wire, sda_o, sda_oe, ack_o, rd_o, ptr_o, dev_rst;
    logic pin0 = 1'b0;
    logic pin1 = 1'b0;
    logic cfg_we = 1'b0;
    logic [2:0] cfg_sel = 3'h0;
    logic [7:0] cfg_data = 8'h00;
    lad_cfg_t cfg;
    lad_hit_t hit;
    int failures = 0;
    int checked = 0;
    localparam logic [35:0] DEF = {8'he0, 8'he8, 8'he4, 8'he2, 4'h8};
    logic [7:0] grp [6] = '{8'he2, 8'he3, 8'he4, 8'he5, 8'he8, 8'he9};
    assign sda_wire = !(sda_low || sda_oe);
    always #20 clk_in = ~clk_in;
    lad_master_model m (.scl_out(scl), .sda_low_out(sda_low),
        .sda_in(sda_wire));
    // Reserved-range regular address, clear of all call values
    lad_addr_decoder #(.PIN_BASE_ADDR(7'h7c)) dut (.clk_in(clk_in),
        .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .addr_pin_0_in(pin0), .addr_pin_1_in(pin1),
        .cfg_we_in(cfg_we), .cfg_sel_in(cfg_sel), .cfg_data_in(cfg_data),
        .cfg_out(cfg), .hit_out(hit), .addr_ack_out(ack_o),
        .read_out(rd_o), .pointer_next_out(ptr_o),
        .device_reset_out(dev_rst));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // A refused byte is followed by one more that must be ignored
    task automatic frame(input logic [7:0] b, input logic exp);
        logic ack;
        m.start();
        m.send(b, ack);
        check(ack, exp);
        check(ack_o, exp);
        if (exp)
            check(rd_o, b[0]);
        else
        begin
            m.send(8'hf8, ack);
            check(ack, 1'b0);
        end
    endtask : frame
    task automatic setcfg(input logic we, input logic [2:0] s,
        input logic [7:0] d);
        @(negedge clk_in);
        cfg_we = we;
        cfg_sel = s;
        cfg_data = d;
    endtask : setcfg
    task automatic t_calls();
        check(cfg, DEF);
        frame(8'he0, 1'b1);
        check(ptr_o, 1'b1);
        frame(8'he1, 1'b1);
        foreach (grp[k])
            frame(grp[k], 1'b0);
        frame(8'h07, 1'b0);
    endtask : t_calls
    task automatic t_regular();
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_in);
            {pin1, pin0} = i[1:0];
            frame({5'h1f, i[1:0], 1'b0}, 1'b1);
            check(ptr_o, 1'b1);
            frame({5'h1f, i[1:0], 1'b1}, 1'b1);
        end
        @(negedge clk_in);
        {pin1, pin0} = 2'b00;
    endtask : t_regular
    task automatic t_program();
        setcfg(1'b1, SEL_ENABLES, 8'h0f);
        frame(8'he5, 1'b1);
        setcfg(1'b1, SEL_GROUP1, 8'h90);
        frame(8'h90, 1'b1);
        check(cfg.group[0], 8'h90);
        setcfg(1'b1, SEL_BROADCAST, 8'hc0);
        frame(8'hc1, 1'b1);
        setcfg(1'b0, SEL_BROADCAST, 8'h00);
        frame(8'he0, 1'b0);
    endtask : t_program
    task automatic t_reset_call();
        int n;
        frame(8'h06, 1'b1);
        check(ptr_o, 1'b0);
        m.stop();
        n = 0;
        while (dev_rst !== 1'b1 && n < 40)
        begin
            @(negedge clk_in);
            n++;
        end
        check(dev_rst, 1'b1);
        check(cfg, DEF);
        @(negedge clk_in);
        check(dev_rst, 1'b0);
        frame(8'he4, 1'b0);
    endtask : t_reset_call
    initial
    begin
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        repeat (6) @(negedge clk_in);
        t_calls();
        t_regular();
        t_program();
        t_reset_call();
        summarize();
    end
    // About 35 us of traffic expected
    initial
    begin
        #100000;
        failures++;
        summarize();
    end
endmodule : testbench
